// [hdl/rcmd_cfg.svh]
// Frame offsets, codes and limits for the remote command frame parser.
// Assumes a byte stream that begins with the start delimiter.
`ifndef RCMD_CFG_SVH
`define RCMD_CFG_SVH
`define START_DELIM       8'h7E
`define TYPE_REMOTE_CMD   8'h17
`define TYPE_TX_STATUS    8'h8B
`define OFS_LEN_MSB       16'h0001
`define OFS_LEN_LSB       16'h0002
`define OFS_TYPE          16'h0003
`define OFS_FRAME_ID      16'h0004
`define OFS_ADDR_FIRST    16'h0005
`define OFS_ADDR_LAST     16'h000C
`define OFS_CMD_OPTS      16'h000F
`define OFS_CMD_HI        16'h0010
`define OFS_CMD_LO        16'h0011
`define OFS_PARAM         16'h0012
`define OPT_APPLY_BIT     1
`define MAX_PARAM_BYTES   8'h10
`define MIN_LENGTH        16'h000F
`endif

// [hdl/rcmd_pkg.sv]
// Types shared by the remote command frame parser.
// Constants live in rcmd_cfg.svh.
package rcmd_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_LEN_H = 3'b001,
    ST_LEN_L = 3'b010,
    ST_BODY  = 3'b011,
    ST_SUM   = 3'b100
  } parse_state_t;

  typedef struct packed {
    logic [7:0]   frame_id;
    logic [31:0]  ip_addr;
    logic         apply_now;
    logic [15:0]  cmd_name;
    logic         is_query;
    logic [7:0]   param_len;
    logic [127:0] param;
  } remote_cmd_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] frame_id;
    logic       ok;
  } tx_status_t;
endpackage : rcmd_pkg

// [hdl/remote_command_frame_codec.sv]
// Parses the remote configuration command frame from the serial byte stream.
// Assumes bytes from the UART deframer on clock_i, one per rx_valid_i pulse.
`timescale 1ns/10ps
`include "rcmd_cfg.svh"

module remote_command_frame_codec
  import rcmd_pkg::*;
(
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  // Received byte stream
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_byte_i,
  // Decoded command and status request
  output remote_cmd_t      cmd_o,
  output logic             cmd_valid_o,
  output logic             apply_o,
  output tx_status_t       status_o,
  output logic             frame_error_o
);

  parse_state_t state;
  logic [15:0]  length;
  logic [15:0]  offset;
  logic [7:0]   sum;
  logic         type_ok;
  remote_cmd_t  work;
  logic [15:0]  last_ofs;

  assign last_ofs = length + 16'h0002;

  // Byte position and parse state
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state  <= ST_IDLE;
      length <= 16'h0000;
      offset <= 16'h0000;
    end else if (rx_valid_i) begin
      offset <= offset + 16'h0001;
      unique case (state)
        ST_IDLE: begin
          offset <= `OFS_LEN_MSB;
          if (rx_byte_i == `START_DELIM) state <= ST_LEN_H;
        end
        ST_LEN_H: begin
          length[15:8] <= rx_byte_i;
          state        <= ST_LEN_L;
        end
        ST_LEN_L: begin
          length[7:0] <= rx_byte_i;
          state       <= ST_BODY;
        end
        ST_BODY: begin
          if (offset >= last_ofs) state <= ST_SUM;
        end
        ST_SUM: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Running sum over type through last data byte
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sum <= 8'h00;
    end else if (rx_valid_i) begin
      if (state == ST_LEN_L) sum <= 8'h00;
      else if (state == ST_BODY) sum <= sum + rx_byte_i;
    end
  end

  // Field capture
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      work    <= '0;
      type_ok <= 1'b0;
    end else if (rx_valid_i && state == ST_LEN_L) begin
      work    <= '0;
      type_ok <= 1'b0;
    end else if (rx_valid_i && state == ST_BODY) begin
      if (offset == `OFS_TYPE) type_ok <= (rx_byte_i == `TYPE_REMOTE_CMD);
      if (offset == `OFS_FRAME_ID) work.frame_id <= rx_byte_i;
      if (offset >= `OFS_ADDR_FIRST + 16'h0004 && offset <= `OFS_ADDR_LAST)
        work.ip_addr <= {work.ip_addr[23:0], rx_byte_i};
      if (offset == `OFS_CMD_OPTS) work.apply_now <= rx_byte_i[`OPT_APPLY_BIT];
      if (offset == `OFS_CMD_HI) work.cmd_name[15:8] <= rx_byte_i;
      if (offset == `OFS_CMD_LO) work.cmd_name[7:0] <= rx_byte_i;
      if (offset >= `OFS_PARAM && work.param_len < `MAX_PARAM_BYTES) begin
        work.param     <= {work.param[119:0], rx_byte_i};
        work.param_len <= work.param_len + 8'h01;
      end
    end
  end

  logic good;
  assign good = type_ok && (length >= `MIN_LENGTH) && ((8'hFF - sum) == rx_byte_i);

  // Frame completion outputs
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cmd_o         <= '0;
      cmd_valid_o   <= 1'b0;
      apply_o       <= 1'b0;
      status_o      <= '0;
      frame_error_o <= 1'b0;
    end else begin
      cmd_valid_o   <= 1'b0;
      apply_o       <= 1'b0;
      status_o.valid <= 1'b0;
      frame_error_o <= 1'b0;
      if (rx_valid_i && state == ST_SUM) begin
        if (good) begin
          cmd_o          <= work;
          cmd_o.is_query <= (work.param_len == 8'h00);
          cmd_valid_o    <= 1'b1;
          apply_o        <= work.apply_now;
        end else begin
          frame_error_o <= 1'b1;
        end
        if (type_ok && work.frame_id != 8'h00) begin
          status_o.valid    <= 1'b1;
          status_o.frame_id <= work.frame_id;
          status_o.ok       <= good;
        end
      end
    end
  end

  // Checks on framing, fields and outputs
  apply_follows_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    apply_o |-> cmd_valid_o && cmd_o.apply_now)
    else $error("apply without flag");

  query_empty_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    cmd_valid_o |-> (cmd_o.is_query == (cmd_o.param_len == 8'h00)))
    else $error("query flag wrong");

  status_nonzero_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    status_o.valid |-> status_o.frame_id != 8'h00)
    else $error("status for id zero");

  no_both_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    !(cmd_valid_o && frame_error_o))
    else $error("accept and reject together");

  status_ok_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    status_o.valid && status_o.ok |-> cmd_valid_o)
    else $error("ok without command");

  pulse_cmd_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    cmd_valid_o |=> !cmd_valid_o)
    else $error("command held");

  sum_end_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (cmd_valid_o || frame_error_o) |-> $past(state) == ST_SUM)
    else $error("late end");

  idle_after_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    cmd_valid_o |-> state == ST_IDLE)
    else $error("not idle after frame");

  type_check_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    rx_valid_i && state == ST_BODY && offset == `OFS_TYPE
      |=> type_ok == ($past(rx_byte_i) == `TYPE_REMOTE_CMD))
    else $error("type flag wrong");

  type_needed_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    cmd_valid_o |-> type_ok)
    else $error("command of wrong type");

  idle_ignore_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    rx_valid_i && state == ST_IDLE && rx_byte_i != `START_DELIM |=> state == ST_IDLE)
    else $error("left idle without delimiter");

  apply_capture_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    rx_valid_i && state == ST_BODY && offset == `OFS_CMD_OPTS
      |=> work.apply_now == $past(rx_byte_i[`OPT_APPLY_BIT]))
    else $error("apply option not captured");

  apply_match_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    cmd_valid_o |-> apply_o == cmd_o.apply_now)
    else $error("apply pulse disagrees with option");

  name_hi_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    rx_valid_i && state == ST_BODY && offset == `OFS_CMD_HI
      |=> work.cmd_name[15:8] == $past(rx_byte_i))
    else $error("first name byte not captured");

  name_lo_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    rx_valid_i && state == ST_BODY && offset == `OFS_CMD_LO
      |=> work.cmd_name[7:0] == $past(rx_byte_i))
    else $error("second name byte not captured");

  param_cap_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    work.param_len <= `MAX_PARAM_BYTES)
    else $error("parameter count above cap");

  param_count_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    rx_valid_i && state == ST_BODY && offset >= `OFS_PARAM && work.param_len < `MAX_PARAM_BYTES
      |=> work.param_len == $past(work.param_len) + 8'h01 && work.param[7:0] == $past(rx_byte_i))
    else $error("parameter byte not captured");

  status_every_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    cmd_valid_o && cmd_o.frame_id != 8'h00 |-> status_o.valid && status_o.ok)
    else $error("status missing for command");

  id_echo_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    status_o.valid |-> status_o.frame_id == work.frame_id)
    else $error("status id not echoed");

  status_match_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    status_o.valid |-> status_o.ok == cmd_valid_o)
    else $error("status result disagrees");

  short_reject_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    rx_valid_i && state == ST_SUM && length < `MIN_LENGTH |=> frame_error_o && !cmd_valid_o)
    else $error("short frame accepted");

  sum_reject_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    rx_valid_i && state == ST_SUM && rx_byte_i != (8'hFF - sum) |=> frame_error_o)
    else $error("bad checksum accepted");

  sum_clear_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    rx_valid_i && state == ST_LEN_L |=> sum == 8'h00)
    else $error("sum not cleared");

  error_pulse_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    frame_error_o |=> !frame_error_o)
    else $error("error held");

endmodule : remote_command_frame_codec

// [verif/host_frame_src.sv]
// Host side: sends remote command frames, one byte per two cycles.
// Assumes a byte sink sampling on the rising clock edge.
`timescale 1ns/10ps
module host_frame_src (
  input  wire logic       clock_i,
  output logic            rx_valid_o,
  output logic [7:0]      rx_byte_o
);
  initial begin
    rx_valid_o = 1'b0;
    rx_byte_o  = 8'hA5;
  end
  task automatic put(input logic [7:0] b);
    @(posedge clock_i); #1;
    rx_valid_o = 1'b1;
    rx_byte_o  = b;
    @(posedge clock_i); #1;
    rx_valid_o = 1'b0;
    rx_byte_o  = ~b;  // Released byte never keeps its value
  endtask : put
  task automatic send(input logic [7:0] typ, id, opt, input logic [31:0] ip,
                      input logic [15:0] cmd, input int np, input logic [127:0] par,
                      input logic bad);
    logic [7:0] q[$];
    logic [7:0] s;
    s = 8'h00;
    q = {typ, id, 8'h00, 8'h00, 8'h00, 8'h00, ip[31:24], ip[23:16], ip[15:8],
         ip[7:0], 8'hFF, 8'hFE, opt, cmd[15:8], cmd[7:0]};
    for (int i = np - 1; i >= 0; i--) q.push_back(par[8*i+:8]);
    put(8'h7E);
    put(8'h00);
    put(8'(q.size()));
    foreach (q[i]) begin
      s = s + q[i];
      put(q[i]);
    end
    put((8'hFF - s) ^ (bad ? 8'h01 : 8'h00));
  endtask : send
endmodule : host_frame_src

// [verif/remote_command_frame_codec_bench.sv]
// Self-checking bench for the remote command frame parser.
// Assumes the host model drives the byte stream.
`timescale 1ns/10ps
module remote_command_frame_codec_bench;
  import rcmd_pkg::*;
  logic        clock_i, rstn_i, rx_valid_i, cmd_valid_o, apply_o, frame_error_o;
  logic [7:0]  rx_byte_i;
  remote_cmd_t cmd_o;
  tx_status_t  status_o;
  int          miscompares = 0, samples_checked = 0, seed = 32'h04e124b7;
  logic [15:0] last_name = 16'h0000;
  logic [7:0]  short_frame [7] = '{8'h55, 8'h7E, 8'h00, 8'h02, 8'h17, 8'h01, 8'hE7};
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  remote_command_frame_codec u_dut (.clock_i(clock_i), .rstn_i(rstn_i), .rx_valid_i(rx_valid_i),
    .rx_byte_i(rx_byte_i), .cmd_o(cmd_o), .cmd_valid_o(cmd_valid_o), .apply_o(apply_o),
    .status_o(status_o), .frame_error_o(frame_error_o));
  host_frame_src u_host (.clock_i(clock_i), .rx_valid_o(rx_valid_i), .rx_byte_o(rx_byte_i));
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task give_verdict;
    if (miscompares == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  function automatic logic [127:0] pm(input int np, input logic [127:0] p);
    return (np == 0) ? '0 : p & ({128{1'b1}} >> (128 - 8 * np));
  endfunction : pm
  task automatic run(input logic [7:0] typ, id, opt, input logic [31:0] ip,
                     input logic [15:0] cmd, input int np, input logic [127:0] par,
                     input logic bad);
    logic good;
    good = (typ == 8'h17) && !bad;
    u_host.send(typ, id, opt, ip, cmd, np, par, bad);
    for (int i = 0; i < 4 && cmd_valid_o !== 1'b1 && frame_error_o !== 1'b1; i++) begin
      @(posedge clock_i); #1;
    end
    chk(cmd_valid_o, good);
    chk(frame_error_o, !good);
    chk(apply_o, good && opt[1]);
    if (typ != 8'h17) chk(status_o.valid, 1'b0);
    if (typ == 8'h17 && id != 8'h00) begin
      chk(status_o.valid, 1'b1);
      chk(status_o.frame_id, id);
      chk(status_o.ok, good);
    end
    if (good) begin
      chk(status_o.valid, id != 8'h00);
      chk(cmd_o.apply_now, opt[1]);
      chk(cmd_o.frame_id, id);
      chk(cmd_o.ip_addr, ip);
      chk(cmd_o.cmd_name, cmd);
      chk(cmd_o.is_query, np == 0);
      chk(cmd_o.param_len, 8'(np));
      chk(pm(np, cmd_o.param), pm(np, par));
      last_name = cmd;
    end else begin
      chk(cmd_o.cmd_name, last_name);
    end
  endtask : run
  initial begin
    rstn_i = 1'b0;
    repeat (8) @(posedge clock_i);
    #1;
    rstn_i = 1'b1;
    chk({cmd_valid_o, apply_o, frame_error_o, status_o.valid}, 4'h0);
    run(8'h17, 8'h01, 8'h02, 32'hC0A80182, 16'h444C, 4, 128'hC0A8018C, 1'b0);
    run(8'h17, 8'h00, 8'h00, 32'hC0A80182, 16'h444C, 0, '0, 1'b0);
    run(8'h17, 8'h05, 8'h02, 32'h0A000001, 16'h444C, 16, '1, 1'b1);
    run(8'h07, 8'h09, 8'h02, 32'h0A000001, 16'h444C, 2, 128'h1234, 1'b0);
    for (int k = 0; k < 20; k++)
      run(8'h17, 8'($random(seed)), 8'($random(seed)) & 8'h02, $random(seed),
          16'($random(seed)), ($random(seed) & 32'h7FFF) % 17, {4{$random(seed)}}, 1'b0);
    foreach (short_frame[i]) u_host.put(short_frame[i]);
    chk(frame_error_o, 1'b1);
    chk(cmd_valid_o, 1'b0);
    chk(status_o.valid, 1'b1);
    chk(status_o.frame_id, 8'h01);
    chk(status_o.ok, 1'b0);
    run(8'h17, 8'h02, 8'h02, 32'hC0A80182, 16'h4143, 0, '0, 1'b0);
    give_verdict;
  end
  initial begin
    #500000;
    miscompares++;
    give_verdict;
  end
endmodule : remote_command_frame_codec_bench
